// File: logic/tpg_map.svh
// Register offsets, field positions, reset values and constants of the pattern generator
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// Directly mapped register offsets
`define OFS_PATTERN_CONTROL   8'h64
`define OFS_PATTERN_CONFIG    8'h65
`define OFS_INDIRECT_ADDRESS  8'h66
`define OFS_INDIRECT_DATA     8'h67
`define OFS_IDENTITY_FIRST    8'hF0

// Reset values
`define RST_PATTERN_CONTROL   8'h10
`define RST_PATTERN_CONFIG    8'h00
`define RST_INDIRECT_ADDRESS  8'h00
`define RST_BYTE              8'h00
`define READ_UNMAPPED         8'h00

// Control register fields
`define CTL_SELECT_HI         7
`define CTL_SELECT_LO         4
`define CTL_ENABLE            0

// Configuration register fields
`define CFG_DEPTH18           4
`define CFG_EXT_CLOCK         3
`define CFG_TIMING_SEL        2
`define CFG_INVERT            1
`define CFG_AUTO_SCROLL       0

// Indirectly mapped register addresses
`define IND_ENABLE_MASK_LO    8'h00
`define IND_ENABLE_MASK_HI    8'h01
`define IND_FRAME_DWELL       8'h02
`define IND_HTOTAL_LO         8'h03
`define IND_HTOTAL_HI         8'h04
`define IND_VTOTAL_LO         8'h05
`define IND_VTOTAL_HI         8'h06
`define IND_HACTIVE_LO        8'h07
`define IND_HACTIVE_HI        8'h08
`define IND_VACTIVE_LO        8'h09
`define IND_VACTIVE_HI        8'h0A
`define IND_HSYNC_WIDTH       8'h0B
`define IND_VSYNC_WIDTH       8'h0C
`define IND_HBACK_PORCH       8'h0D
`define IND_VBACK_PORCH       8'h0E
`define IND_SYNC_CONFIG       8'h0F
`define IND_CUSTOM_RED        8'h10
`define IND_CUSTOM_GREEN      8'h11
`define IND_CUSTOM_BLUE       8'h12
`define SYNC_HS_POL           0
`define SYNC_VS_POL           1

// Patterns that may take part in scrolling (codes 0 and 15 are reserved)
`define PAT_VALID_MASK        16'h7FFE

// Colour constants
`define COLOR_FULL            8'hFF
`define COLOR_NONE            8'h00
`define DEPTH18_MASK          8'hFC

// Counter constants
`define COUNT_ZERO12          12'h000
`define COUNT_ONE12           12'h001
`define FRAMES_ZERO           8'h00
`define FRAMES_ONE            8'h01

`endif

// File: logic/tpg_pkg.sv
// Types shared by the pattern generator design files
`default_nettype none
package tpg_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [11:0] count_t;
    typedef enum logic [3:0] {
        PAT_RESERVED_LO = 4'h0,
        PAT_WHITE       = 4'h1,
        PAT_BLACK       = 4'h2,
        PAT_RED         = 4'h3,
        PAT_GREEN       = 4'h4,
        PAT_BLUE        = 4'h5,
        PAT_H_GRAY      = 4'h6,
        PAT_H_RED       = 4'h7,
        PAT_H_GREEN     = 4'h8,
        PAT_H_BLUE      = 4'h9,
        PAT_V_GRAY      = 4'hA,
        PAT_V_RED       = 4'hB,
        PAT_V_GREEN     = 4'hC,
        PAT_V_BLUE      = 4'hD,
        PAT_CUSTOM      = 4'hE,
        PAT_RESERVED_HI = 4'hF
    } pattern_t;
endpackage
`default_nettype wire

// File: logic/pattern_sequencer.sv
// Frame dwell counter and pattern selection for fixed and auto-scroll operation
`include "tpg_map.svh"
`default_nettype none
module pattern_sequencer (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             auto_scroll,
    input  wire logic [3:0]       fixed_select,
    input  wire logic [15:0]      enable_mask,
    input  wire tpg_pkg::byte_t   frame_dwell_count,
    input  wire logic             frame_start,
    output var  tpg_pkg::pattern_t current_pattern
);
    tpg_pkg::byte_t    frame_cnt;
    logic              dwell_done;
    logic [15:0]       usable_mask;
    tpg_pkg::pattern_t next_pattern;

    // Next enabled pattern after the current one, wrapping; stays if none
    function automatic tpg_pkg::pattern_t next_enabled(input logic [3:0] cur,
                                                      input logic [15:0] mask);
        logic [3:0] idx;
        logic       found;
        next_enabled = tpg_pkg::pattern_t'(cur);
        found = 1'b0;
        for (int i = 1; i < 16; i++) begin
            idx = cur + 4'(i);
            if (!found && mask[idx]) begin
                next_enabled = tpg_pkg::pattern_t'(idx);
                found = 1'b1;
            end
        end
    endfunction

    // Dwell reached after the programmed number of frames; zero means every frame
    assign usable_mask  = enable_mask & `PAT_VALID_MASK;
    assign dwell_done   = (frame_dwell_count == `FRAMES_ZERO) ||
                          (frame_cnt == frame_dwell_count - `FRAMES_ONE);
    assign next_pattern = next_enabled(current_pattern, usable_mask);

    // Fixed select when not scrolling, otherwise advance on dwell expiry
    always_ff @(posedge clk) begin
        if (rst) begin
            current_pattern <= tpg_pkg::PAT_RESERVED_LO;
            frame_cnt       <= `FRAMES_ZERO;
        end else if (!auto_scroll) begin
            current_pattern <= tpg_pkg::pattern_t'(fixed_select); // see [RULE_08]
            frame_cnt       <= `FRAMES_ZERO;
        end else if (frame_start) begin
            if (dwell_done) begin
                current_pattern <= next_pattern; // see [RULE_05]
                frame_cnt       <= `FRAMES_ZERO;
            end else begin
                frame_cnt <= frame_cnt + `FRAMES_ONE;
            end
        end
    end

    // Pattern only moves at a frame start while scrolling
    a_scroll_hold: assert property (@(posedge clk) disable iff (rst) // see [RULE_05]
        auto_scroll && $past(auto_scroll) && !frame_start |=> $stable(current_pattern))
        else $error("pattern changed outside a frame start");

    // Dwell expiry moves to the next enabled pattern
    a_scroll_advance: assert property (@(posedge clk) disable iff (rst) // see [RULE_05]
        auto_scroll && frame_start && dwell_done |=> current_pattern == $past(next_pattern))
        else $error("pattern did not advance on dwell expiry");

    c_scroll_advance: cover property (@(posedge clk) disable iff (rst)
        auto_scroll && frame_start && dwell_done && next_pattern != current_pattern);
endmodule
`default_nettype wire

// File: logic/test_pattern_generator_config.sv
// Test pattern generator configuration, indirect register access and pixel output
//
// Functional notes
// [RULE_01] Depth bit set: 18-bit, 64 steps, six MSBs; clear: 24-bit, 256 steps.
// [RULE_02] Internal timing: clock bit picks pixel clock or divided clock; ignored otherwise.
// [RULE_03] Timing bit set: own timing from programmed sizes; clear: follow incoming syncs.
// [RULE_04] Invert bit set outputs inverted pattern colours; clear outputs them as is.
// [RULE_05] Auto-scroll advances to next enabled pattern after dwell frames; else holds.
// [RULE_06] Software loads the indirect address before each indirect data access.
// [RULE_07] Indirect data write stores to addressed register; read returns its value.
// [RULE_08] Fixed select chooses the pattern; ignored while auto-scroll is enabled.
// [RULE_09] Patterns are generated only while the enable bit is set.
// [RULE_10] Indirect address stays unchanged after an indirect data access.
`include "tpg_map.svh"
`default_nettype none
module test_pattern_generator_config #(
    parameter logic [7:0] IDENTITY_BYTE = 8'hA5 // Arbitrary value
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             REG_RVALID_O,
    input  wire logic [23:0] VIDEO_RGB_I,
    input  wire logic        VIDEO_DE_I,
    input  wire logic        VIDEO_HS_I,
    input  wire logic        VIDEO_VS_I,
    output logic      [23:0] VIDEO_RGB_O,
    output logic             VIDEO_DE_O,
    output logic             VIDEO_HS_O,
    output logic             VIDEO_VS_O
);
    tpg_pkg::byte_t    pattern_control;
    tpg_pkg::byte_t    pattern_configuration;
    tpg_pkg::byte_t    indirect_address;
    tpg_pkg::byte_t    ind_mem [0:255];
    tpg_pkg::pattern_t current_pattern;
    tpg_pkg::count_t   h_cnt, v_cnt, ext_h, ext_v;
    logic              div_phase, ext_vs_q, ext_de_q;

    // Write of one register of the table
    function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] o);
        wr_hit = we && (a == o);
    endfunction

    // Twelve-bit size from a low byte and the low nibble of a high byte
    function automatic tpg_pkg::count_t word12(input tpg_pkg::byte_t lo, input tpg_pkg::byte_t hi);
        word12 = {hi[3:0], lo};
    endfunction

    // Decoded fields
    wire       gen_enable  = pattern_control[`CTL_ENABLE];
    wire [3:0] fixed_sel   = pattern_control[`CTL_SELECT_HI:`CTL_SELECT_LO];
    wire       depth18     = pattern_configuration[`CFG_DEPTH18];
    wire       ext_clock   = pattern_configuration[`CFG_EXT_CLOCK];
    wire       timing_source_select = pattern_configuration[`CFG_TIMING_SEL];
    wire       invert      = pattern_configuration[`CFG_INVERT];
    wire       auto_scroll = pattern_configuration[`CFG_AUTO_SCROLL];
    wire [7:0] frame_dwell_count = ind_mem[`IND_FRAME_DWELL];
    wire [15:0] enable_mask = {ind_mem[`IND_ENABLE_MASK_HI], ind_mem[`IND_ENABLE_MASK_LO]};
    wire [7:0] ind_rd_val  = ind_mem[indirect_address]; // see [RULE_07]

    // Bus write strobes
    wire wr_ctl  = wr_hit(REG_WR_I, REG_ADDR_I, `OFS_PATTERN_CONTROL);
    wire wr_cfg  = wr_hit(REG_WR_I, REG_ADDR_I, `OFS_PATTERN_CONFIG);
    wire wr_addr = wr_hit(REG_WR_I, REG_ADDR_I, `OFS_INDIRECT_ADDRESS);
    wire wr_data = wr_hit(REG_WR_I, REG_ADDR_I, `OFS_INDIRECT_DATA);

    // Read multiplexer; unmapped addresses read zero
    wire [7:0] rd_mux =
        (REG_ADDR_I == `OFS_PATTERN_CONTROL)  ? pattern_control :
        (REG_ADDR_I == `OFS_PATTERN_CONFIG)   ? pattern_configuration :
        (REG_ADDR_I == `OFS_INDIRECT_ADDRESS) ? indirect_address :
        (REG_ADDR_I == `OFS_INDIRECT_DATA)    ? ind_rd_val :
        (REG_ADDR_I == `OFS_IDENTITY_FIRST)   ? IDENTITY_BYTE : `READ_UNMAPPED;

    // Direct registers; address only changes on its own write
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pattern_control       <= `RST_PATTERN_CONTROL;
            pattern_configuration <= `RST_PATTERN_CONFIG;
            indirect_address      <= `RST_INDIRECT_ADDRESS;
        end else begin
            if (wr_ctl)  pattern_control       <= REG_WDATA_I;
            if (wr_cfg)  pattern_configuration <= REG_WDATA_I;
            if (wr_addr) indirect_address      <= REG_WDATA_I; // see [RULE_06] [RULE_10]
        end
    end

    // Indirectly mapped registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 256; i++) ind_mem[i] <= `RST_BYTE;
        end else if (wr_data) begin
            ind_mem[indirect_address] <= REG_WDATA_I; // see [RULE_07]
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            REG_RDATA_O  <= `READ_UNMAPPED;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) REG_RDATA_O <= rd_mux;
        end
    end

    // Internal timing parameters
    wire [11:0] h_total  = word12(ind_mem[`IND_HTOTAL_LO], ind_mem[`IND_HTOTAL_HI]);
    wire [11:0] v_total  = word12(ind_mem[`IND_VTOTAL_LO], ind_mem[`IND_VTOTAL_HI]);
    wire [11:0] h_active = word12(ind_mem[`IND_HACTIVE_LO], ind_mem[`IND_HACTIVE_HI]);
    wire [11:0] v_active = word12(ind_mem[`IND_VACTIVE_LO], ind_mem[`IND_VACTIVE_HI]);
    wire [11:0] h_start  = {4'h0, ind_mem[`IND_HSYNC_WIDTH]} + {4'h0, ind_mem[`IND_HBACK_PORCH]};
    wire [11:0] v_start  = {4'h0, ind_mem[`IND_VSYNC_WIDTH]} + {4'h0, ind_mem[`IND_VBACK_PORCH]};
    wire [7:0]  sync_cfg = ind_mem[`IND_SYNC_CONFIG];

    // Pixel rate: every cycle from the pixel clock, every other from the divider
    wire pix_tick = !timing_source_select || ext_clock || div_phase; // see [RULE_02]
    wire h_last   = (h_cnt >= h_total - `COUNT_ONE12);
    wire v_last   = (v_cnt >= v_total - `COUNT_ONE12);

    // Internal frame counters
    always_ff @(posedge CLK_I) begin
        if (RST_I || !timing_source_select || !gen_enable) begin
            h_cnt     <= `COUNT_ZERO12;
            v_cnt     <= `COUNT_ZERO12;
            div_phase <= 1'b0;
        end else begin
            div_phase <= !div_phase;
            if (pix_tick) begin
                h_cnt <= h_last ? `COUNT_ZERO12 : h_cnt + `COUNT_ONE12; // see [RULE_03]
                if (h_last) v_cnt <= v_last ? `COUNT_ZERO12 : v_cnt + `COUNT_ONE12;
            end
        end
    end

    // Position within incoming video, for external timing
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ext_h    <= `COUNT_ZERO12;
            ext_v    <= `COUNT_ZERO12;
            ext_vs_q <= 1'b0;
            ext_de_q <= 1'b0;
        end else begin
            ext_vs_q <= VIDEO_VS_I;
            ext_de_q <= VIDEO_DE_I;
            ext_h    <= VIDEO_DE_I ? ext_h + `COUNT_ONE12 : `COUNT_ZERO12;
            if (VIDEO_VS_I) ext_v <= `COUNT_ZERO12;
            else if (ext_de_q && !VIDEO_DE_I) ext_v <= ext_v + `COUNT_ONE12;
        end
    end

    // Timing selection between internal and external sources
    wire int_de = (h_cnt >= h_start) && (h_cnt < h_start + h_active) &&
                  (v_cnt >= v_start) && (v_cnt < v_start + v_active);
    wire int_hs = (h_cnt < {4'h0, ind_mem[`IND_HSYNC_WIDTH]}) ^ sync_cfg[`SYNC_HS_POL];
    wire int_vs = (v_cnt < {4'h0, ind_mem[`IND_VSYNC_WIDTH]}) ^ sync_cfg[`SYNC_VS_POL];
    wire px_de  = timing_source_select ? int_de : VIDEO_DE_I; // see [RULE_03]
    wire px_hs  = timing_source_select ? int_hs : VIDEO_HS_I;
    wire px_vs  = timing_source_select ? int_vs : VIDEO_VS_I;
    wire [11:0] pos_h = timing_source_select ? h_cnt - h_start : ext_h;
    wire [11:0] pos_v = timing_source_select ? v_cnt - v_start : ext_v;
    wire frame_start  = timing_source_select ?
                        (pix_tick && h_last && v_last) : (VIDEO_VS_I && !ext_vs_q);

    pattern_sequencer u_sequencer (
        .clk               (CLK_I),
        .rst               (RST_I),
        .auto_scroll       (auto_scroll),
        .fixed_select      (fixed_sel),
        .enable_mask       (enable_mask),
        .frame_dwell_count (frame_dwell_count),
        .frame_start       (frame_start),
        .current_pattern   (current_pattern)
    );

    // Pattern colour: ramp level and {red, green, blue} channel weights
    wire [7:0] ramp = (current_pattern >= tpg_pkg::PAT_V_GRAY) ? pos_v[7:0] : pos_h[7:0];
    wire [2:0] chan =
        (current_pattern == tpg_pkg::PAT_RED   || current_pattern == tpg_pkg::PAT_H_RED ||
         current_pattern == tpg_pkg::PAT_V_RED)   ? 3'h4 :
        (current_pattern == tpg_pkg::PAT_GREEN || current_pattern == tpg_pkg::PAT_H_GREEN ||
         current_pattern == tpg_pkg::PAT_V_GREEN) ? 3'h2 :
        (current_pattern == tpg_pkg::PAT_BLUE  || current_pattern == tpg_pkg::PAT_H_BLUE ||
         current_pattern == tpg_pkg::PAT_V_BLUE)  ? 3'h1 :
        (current_pattern == tpg_pkg::PAT_WHITE || current_pattern == tpg_pkg::PAT_H_GRAY ||
         current_pattern == tpg_pkg::PAT_V_GRAY)  ? 3'h7 : 3'h0;
    wire scaled = (current_pattern >= tpg_pkg::PAT_H_GRAY) &&
                  (current_pattern <= tpg_pkg::PAT_V_BLUE);
    wire [7:0] level = scaled ? ramp : `COLOR_FULL;
    wire [23:0] base_rgb = (current_pattern == tpg_pkg::PAT_CUSTOM) ?
        {ind_mem[`IND_CUSTOM_RED], ind_mem[`IND_CUSTOM_GREEN], ind_mem[`IND_CUSTOM_BLUE]} :
        {chan[2] ? level : `COLOR_NONE, chan[1] ? level : `COLOR_NONE,
         chan[0] ? level : `COLOR_NONE};
    wire [23:0] inv_rgb = invert ? ~base_rgb : base_rgb; // see [RULE_04]
    wire [7:0]  dmask   = depth18 ? `DEPTH18_MASK : `COLOR_FULL; // see [RULE_01]
    wire [23:0] pat_rgb = px_de ? (inv_rgb & {dmask, dmask, dmask}) : 24'h000000;

    // Output stage: pattern while enabled, incoming video otherwise
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            VIDEO_RGB_O <= 24'h000000;
            VIDEO_DE_O  <= 1'b0;
            VIDEO_HS_O  <= 1'b0;
            VIDEO_VS_O  <= 1'b0;
        end else begin
            VIDEO_RGB_O <= gen_enable ? pat_rgb : VIDEO_RGB_I; // see [RULE_09]
            VIDEO_DE_O  <= gen_enable ? px_de : VIDEO_DE_I;
            VIDEO_HS_O  <= gen_enable ? px_hs : VIDEO_HS_I;
            VIDEO_VS_O  <= gen_enable ? px_vs : VIDEO_VS_I;
        end
    end

    a_indirect_read: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_07]
        REG_RD_I && REG_ADDR_I == `OFS_INDIRECT_DATA |=>
        REG_RVALID_O && REG_RDATA_O == $past(ind_rd_val))
        else $error("indirect read returned wrong value");
    a_indirect_write: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_07]
        wr_data |=> ind_mem[$past(indirect_address)] == $past(REG_WDATA_I))
        else $error("indirect write not stored");
    a_address_kept: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_10]
        !wr_addr |=> indirect_address == $past(indirect_address))
        else $error("indirect address changed without a write");
    a_disabled_pass: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_09]
        !gen_enable |=> VIDEO_RGB_O == $past(VIDEO_RGB_I) && VIDEO_DE_O == $past(VIDEO_DE_I))
        else $error("video not passed while generator disabled");
    a_depth_low_bits: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_01]
        gen_enable && depth18 |=> VIDEO_RGB_O[1:0] == 2'h0 && VIDEO_RGB_O[9:8] == 2'h0 &&
        VIDEO_RGB_O[17:16] == 2'h0)
        else $error("18-bit mode left low colour bits set");
    a_invert_white: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_04]
        gen_enable && px_de && current_pattern == tpg_pkg::PAT_WHITE && !depth18 |=>
        VIDEO_RGB_O == ($past(invert) ? 24'h000000 : 24'hFFFFFF))
        else $error("white pattern colour or inversion wrong");
    a_external_timing: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_03]
        gen_enable && !timing_source_select |=> VIDEO_DE_O == $past(VIDEO_DE_I) &&
        VIDEO_HS_O == $past(VIDEO_HS_I) && VIDEO_VS_O == $past(VIDEO_VS_I))
        else $error("external timing not followed");
    a_divided_clock: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_02]
        gen_enable && timing_source_select && !ext_clock && $past(gen_enable) &&
        $past(timing_source_select) && $past(ext_clock) == 1'b0 |-> pix_tick != $past(pix_tick))
        else $error("divided pixel rate not alternating");
    a_fixed_select: assert property (@(posedge CLK_I) disable iff (RST_I) // see [RULE_08]
        !auto_scroll |=> current_pattern == $past(fixed_sel))
        else $error("fixed pattern select not applied");

    c_indirect_write_read: cover property (@(posedge CLK_I) disable iff (RST_I)
        wr_data ##[1:2] (REG_RD_I && REG_ADDR_I == `OFS_INDIRECT_DATA));
    c_internal_frame: cover property (@(posedge CLK_I) disable iff (RST_I)
        gen_enable && timing_source_select && frame_start);
    c_inverted_active: cover property (@(posedge CLK_I) disable iff (RST_I)
        gen_enable && invert && px_de);
endmodule
`default_nettype wire

// File: test/test_pattern_generator_config_tb.sv
// Self-checking bench for the pattern generator configuration block
`include "tpg_map.svh"
`default_nettype none
module test_pattern_generator_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_VALUE = 8'h3C; // Arbitrary value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [23:0] rgb_i = 24'h000000;
    logic        de_i = 1'b0;
    logic        hs_i = 1'b0;
    logic        vs_i = 1'b0;
    logic [23:0] rgb_o;
    logic        de_o;
    logic        hs_o;
    logic        vs_o;
    int          fails = 0;
    int          n_checks = 0;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [23:0] prev_rgb;
    logic [7:0]  timing [16] = '{8'h08, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00,
                                 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

    test_pattern_generator_config #(.IDENTITY_BYTE(ID_VALUE)) test_pattern_generator_config_inst (
        .CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .VIDEO_RGB_I(rgb_i), .VIDEO_DE_I(de_i), .VIDEO_HS_I(hs_i), .VIDEO_VS_I(vs_i),
        .VIDEO_RGB_O(rgb_o), .VIDEO_DE_O(de_o), .VIDEO_HS_O(hs_o), .VIDEO_VS_O(vs_o)
    );

    // Clock of 5 ns period
    always #2.5 clk = ~clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe at the falling edge
    task automatic wreg(input logic [7:0] ad, input logic [7:0] dt);
        @(negedge clk);
        addr = ad; wdata = dt; wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Read strobe, answer checked one cycle later
    task automatic rreg(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk);
        addr = ad; rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(24'(rvalid), 24'h1, "read valid");
        chk(24'(rdata), 24'(exp), "read data");
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Expected colour of a solid pattern
    function automatic logic [23:0] solid(input logic [3:0] p, input logic inv, input logic d18);
        logic [23:0] c;
        case (p)
            4'h1: c = 24'hFFFFFF;
            4'h3: c = 24'hFF0000;
            4'h4: c = 24'h00FF00;
            4'h5: c = 24'h0000FF;
            default: c = 24'h000000;
        endcase
        if (inv) c = ~c;
        if (d18) c = c & {3{`DEPTH18_MASK}};
        return c;
    endfunction

    // Cycles between two rising edges of the sync output
    task automatic hs_period(input int exp);
        int first;
        int cnt;
        logic prev;
        first = 0; cnt = 0; prev = 1'b1;
        for (int i = 0; i < 200 && cnt < 2; i++) begin
            @(negedge clk);
            if (hs_o && !prev) begin
                if (cnt == 1) chk(24'(i - first), 24'(exp), "sync period");
                first = i;
                cnt++;
            end
            prev = hs_o;
        end
        if (cnt < 2) begin
            fails++;
            $display("MISMATCH at %0t: no sync pulses", $time);
            conclude();
        end
    endtask

    // Frame start seen as a rising incoming vertical sync
    task automatic vs_pulse(input logic [23:0] exp);
        @(negedge clk) vs_i = 1'b1;
        idle(2);
        vs_i = 1'b0;
        idle(4);
        chk(rgb_o, exp, "scroll colour");
    endtask

    initial begin
        void'($urandom(32'h3357b54a));
        idle(2);
        rst = 1'b0;
        rreg(`OFS_PATTERN_CONTROL, `RST_PATTERN_CONTROL);
        rreg(`OFS_PATTERN_CONFIG, `RST_PATTERN_CONFIG);
        rreg(`OFS_INDIRECT_ADDRESS, `RST_INDIRECT_ADDRESS);
        rreg(`OFS_INDIRECT_DATA, `RST_BYTE);
        rreg(`OFS_IDENTITY_FIRST, ID_VALUE);
        wreg(`OFS_IDENTITY_FIRST, 8'h00);
        rreg(`OFS_IDENTITY_FIRST, ID_VALUE);
        rreg(8'h80, `READ_UNMAPPED);
        $display("test reset and map done");
        // Random indirect bytes in plain storage, address loaded first
        for (int i = 0; i < 8; i++) begin
            a = 8'($urandom_range(8'hFF, 8'h13));
            d = 8'($urandom);
            wreg(`OFS_INDIRECT_ADDRESS, a);
            wreg(`OFS_INDIRECT_DATA, d);
            rreg(`OFS_INDIRECT_DATA, d);
            rreg(`OFS_INDIRECT_ADDRESS, a);
        end
        d = 8'($urandom) & 8'h1C;
        wreg(`OFS_PATTERN_CONFIG, d);
        rreg(`OFS_PATTERN_CONFIG, d);
        $display("test indirect access done");
        // Disabled generator passes random video through
        wreg(`OFS_PATTERN_CONFIG, 8'h00);
        for (int i = 0; i < 16; i++) begin
            prev_rgb = 24'($urandom);
            rgb_i = prev_rgb;
            de_i = i[0];
            hs_i = i[2];
            vs_i = i[1];
            @(negedge clk);
            chk(rgb_o, prev_rgb, "pass through");
            chk(24'(de_o), 24'(i[0]), "pass de");
            chk(24'({hs_o, vs_o}), 24'(i[2:1]), "pass syncs");
        end
        hs_i = 1'b0;
        vs_i = 1'b0;
        $display("test pass through done");
        // Solid patterns white, black, red, green and blue under invert and depth settings
        de_i = 1'b1;
        for (int p = 1; p < 6; p++) begin
            for (int m = 0; m < 4; m++) begin
                wreg(`OFS_PATTERN_CONFIG, {3'h0, m[1], 2'b00, m[0], 1'b0});
                wreg(`OFS_PATTERN_CONTROL, {p[3:0], 4'h1});
                idle(3);
                chk(rgb_o, solid(p[3:0], m[0], m[1]), "solid");
            end
        end
        @(negedge clk) de_i = 1'b0;
        idle(2);
        chk(rgb_o, 24'h000000, "blank outside de");
        de_i = 1'b1;
        $display("test solid patterns done");
        // Auto-scroll over patterns 2 and 3 with one frame dwell
        wreg(`OFS_PATTERN_CONFIG, 8'h00);
        wreg(`OFS_PATTERN_CONTROL, 8'h11);
        for (int i = 0; i < 3; i++) begin
            wreg(`OFS_INDIRECT_ADDRESS, `IND_ENABLE_MASK_LO + 8'(i));
            wreg(`OFS_INDIRECT_DATA, (i == 0) ? 8'h0C : (i == 2) ? 8'h01 : 8'h00);
        end
        wreg(`OFS_PATTERN_CONFIG, 8'h01);
        wreg(`OFS_PATTERN_CONTROL, 8'h51);
        idle(3);
        chk(rgb_o, 24'hFFFFFF, "select ignored");
        vs_pulse(24'h000000);
        vs_pulse(24'hFF0000);
        vs_pulse(24'h000000);
        $display("test auto scroll done");
        // Internal timing from programmed sizes, both clock sources
        for (int i = 0; i < 13; i++) begin
            wreg(`OFS_INDIRECT_ADDRESS, `IND_HTOTAL_LO + 8'(i));
            wreg(`OFS_INDIRECT_DATA, timing[i]);
        end
        de_i = 1'b0;
        wreg(`OFS_PATTERN_CONTROL, 8'h11);
        wreg(`OFS_PATTERN_CONFIG, 8'h0C);
        hs_period(8);
        wreg(`OFS_PATTERN_CONFIG, 8'h04);
        hs_period(16);
        $display("test internal timing done");
        conclude();
    end
endmodule
`default_nettype wire
